// ### shared/ebsl_pkg.sv
/*
 constants, field layout and carrier types of the error bank status logger.
 assumes one clock domain; the error source presents at most one event per cycle.
*/
package ebsl_pkg;
   localparam int NUM_BANKS = 5;
   localparam int CB_BANK   = 4;
   localparam int POS_MODEL = 16;
   localparam int POS_OTHER = 32;
   localparam int POS_CNT   = 32;
   localparam int POS_FMT   = 40;
   localparam int POS_PCC   = 57;
   localparam int POS_ADDRESS_VALID_FLAG = 58;
   localparam int POS_EXTRA_INFO_VALID_FLAG = 59;
   localparam int POS_EN    = 60;
   localparam int POS_UC    = 61;
   localparam int POS_OVER  = 62;
   localparam int POS_VAL   = 63;
   localparam logic [15:0] CODE_INTERNAL = 16'h0400;
   localparam logic [15:0] CODE_L3TAG    = 16'h010b;
   localparam logic [15:0] CODE_BUS      = 16'h0e0f;
   localparam logic [7:0]  CNT_FIRST     = 8'h01;
   localparam logic [7:0]  CNT_MAX       = 8'hff;
   localparam logic [7:0]  CNT_RST       = 8'h00;
   localparam logic [63:0] STAT_RST      = 64'h0;
   localparam logic [7:0]  CTL_RST       = 8'h00;
   // word address: bits 5:3 select the bank, bits 2:0 the register
   localparam logic [2:0]  REG_STAT_LO   = 3'h0;
   localparam logic [2:0]  REG_STAT_HI   = 3'h1;
   localparam logic [2:0]  REG_ADDR      = 3'h2;
   localparam logic [2:0]  REG_MISC      = 3'h3;
   localparam logic [2:0]  REG_CTL       = 3'h4;
   localparam int          HI_VAL        = POS_VAL - 32;
   localparam int          HI_OVER       = POS_OVER - 32;

   typedef enum logic [1:0] {
      EBSL_INTERNAL = 2'b00,
      EBSL_L3TAG    = 2'b01,
      EBSL_BUS      = 2'b11
   } ebsl_kind_type;

   typedef struct packed {
      logic          valid;
      logic [2:0]    bank;
      ebsl_kind_type kind;
      logic [15:0]   arch_code;
      logic [15:0]   model_code;
      logic [24:0]   other_info;
      logic [1:0]    misc_fmt;
      logic [2:0]    ctl_idx;
      logic          uc;
      logic          context_corrupt_flag;
      logic          addr_valid;
      logic [31:0]   address;
      logic          misc_valid;
      logic [31:0]   misc;
   } ebsl_event_type;

   typedef struct packed {
      logic [63:0] status;
      logic [31:0] addr;
      logic [31:0] misc;
   } ebsl_entry_type;

   typedef struct packed {
      ebsl_entry_type [NUM_BANKS-1:0] ent;
      logic [NUM_BANKS-1:0][7:0]      ctl;
      logic [7:0]                     cnt;
      logic [31:0]                    rdata;
      logic [NUM_BANKS-1:0]           vflag;
   } ebsl_state_type;
endpackage : ebsl_pkg

// ### verilog/ebsl_bank.sv
/*
 next-entry logic of one error bank: software clears, then overwrite priority.
 assumes a fully formed candidate entry; valid and overflow bits of it are ignored.
*/
`timescale 1ns/100ps
`default_nettype none
module ebsl_bank (
   // current entry and clears
   input  wire ebsl_pkg::ebsl_entry_type old_ent,
   input  wire logic                     clr_val,
   input  wire logic                     clr_over,
   // new error
   input  wire logic                     hit,
   input  wire ebsl_pkg::ebsl_entry_type cand,
   // result
   output ebsl_pkg::ebsl_entry_type      nxt_ent
);
   logic live;
   logic over_keep;
   logic replace;

   always_comb begin
      // clear goes first so that a same-cycle event still sets the valid flag
      live      = old_ent.status[ebsl_pkg::POS_VAL] & ~clr_val;
      over_keep = old_ent.status[ebsl_pkg::POS_OVER] & ~clr_over;
      replace   = ~(old_ent.status[ebsl_pkg::POS_UC] & cand.status[ebsl_pkg::POS_UC]) &
                  ((cand.status[ebsl_pkg::POS_EN] & ~old_ent.status[ebsl_pkg::POS_EN]) |
                   (cand.status[ebsl_pkg::POS_UC] & ~old_ent.status[ebsl_pkg::POS_UC]));
      nxt_ent = old_ent;
      nxt_ent.status[ebsl_pkg::POS_VAL]  = live;
      nxt_ent.status[ebsl_pkg::POS_OVER] = over_keep;
      if (hit) begin
         if (!live || replace) begin
            nxt_ent = cand;
         end
         nxt_ent.status[ebsl_pkg::POS_VAL]  = 1'b1;
         nxt_ent.status[ebsl_pkg::POS_OVER] = over_keep | live;
      end
   end
endmodule : ebsl_bank
`default_nettype wire

// ### verilog/ebsl_top.sv
/*
 error bank status logger: five status banks with address, extra-info and
 report-control registers behind a plain register port.
 assumes the error source shares mclk and drives one event per cycle at most.
*/
`timescale 1ns/100ps
`default_nettype none
module ebsl_top (
   // clock and reset
   input  wire  logic                     mclk,
   input  wire  logic                     rst,
   // register port
   input  wire  logic [5:0]               reg_addr,
   input  wire  logic [31:0]              reg_wdata,
   input  wire  logic                     reg_wr,
   input  wire  logic                     reg_rd,
   output logic [31:0]                    reg_rdata,
   // error source
   input  wire  ebsl_pkg::ebsl_event_type err_ev,
   // entry-valid flags per bank
   output logic [ebsl_pkg::NUM_BANKS-1:0] bank_valid
);
   ebsl_pkg::ebsl_state_type                         s_r;
   ebsl_pkg::ebsl_state_type                         s_nxt;
   ebsl_pkg::ebsl_entry_type [ebsl_pkg::NUM_BANKS-1:0] cand;
   ebsl_pkg::ebsl_entry_type [ebsl_pkg::NUM_BANKS-1:0] ent_w;
   logic [ebsl_pkg::NUM_BANKS-1:0]                   hit;
   logic [ebsl_pkg::NUM_BANKS-1:0]                   clr_val;
   logic [ebsl_pkg::NUM_BANKS-1:0]                   clr_over;
   logic [15:0]                                      cb_code;
   logic                                             ce_ev;
   logic [7:0]                                       cnt_nxt;
   logic [2:0]                                       sel_bank;
   logic [2:0]                                       sel_reg;
   logic                                             bank_ok;

   assign sel_bank = reg_addr[5:3];
   assign sel_reg  = reg_addr[2:0];
   assign bank_ok  = (sel_bank < 3'(ebsl_pkg::NUM_BANKS));

   // only the three legal codes can come out of this mux
   always_comb begin
      case (err_ev.kind)
         ebsl_pkg::EBSL_INTERNAL: cb_code = ebsl_pkg::CODE_INTERNAL;
         ebsl_pkg::EBSL_L3TAG:    cb_code = ebsl_pkg::CODE_L3TAG;
         ebsl_pkg::EBSL_BUS:      cb_code = ebsl_pkg::CODE_BUS;
         default:                 cb_code = ebsl_pkg::CODE_INTERNAL;
      endcase
   end

   // counts every correctable event in the cache/bus bank, logged or not
   assign ce_ev   = err_ev.valid && (err_ev.bank == 3'(ebsl_pkg::CB_BANK)) && !err_ev.uc;
   assign cnt_nxt = (ce_ev && (s_r.cnt != ebsl_pkg::CNT_MAX)) ?
                    8'(s_r.cnt + ebsl_pkg::CNT_FIRST) : s_r.cnt;

   genvar b;
   generate
      for (b = 0; b < ebsl_pkg::NUM_BANKS; b++) begin : g_bank
         logic [15:0] code;
         logic [24:0] other;

         assign hit[b] = err_ev.valid && (err_ev.bank == 3'(b));
         assign clr_val[b] = reg_wr && bank_ok && (sel_bank == 3'(b)) &&
                             (sel_reg == ebsl_pkg::REG_STAT_HI) &&
                             !reg_wdata[ebsl_pkg::HI_VAL];
         assign clr_over[b] = reg_wr && bank_ok && (sel_bank == 3'(b)) &&
                              (sel_reg == ebsl_pkg::REG_STAT_HI) &&
                              !reg_wdata[ebsl_pkg::HI_OVER];
         if (b == ebsl_pkg::CB_BANK) begin : g_cb
            assign code  = cb_code;
            // count and format share one layout for all three kinds
            assign other = {err_ev.other_info[24:10], err_ev.misc_fmt, cnt_nxt};
         end else begin : g_plain
            assign code  = err_ev.arch_code;
            assign other = err_ev.other_info;
         end
         always_comb begin
            cand[b].status = ebsl_pkg::STAT_RST;
            cand[b].status[ebsl_pkg::POS_MODEL-1:0] = code;
            cand[b].status[ebsl_pkg::POS_OTHER-1:ebsl_pkg::POS_MODEL] = err_ev.model_code;
            cand[b].status[ebsl_pkg::POS_PCC-1:ebsl_pkg::POS_OTHER] = other;
            cand[b].status[ebsl_pkg::POS_PCC]   = err_ev.context_corrupt_flag | err_ev.uc;
            cand[b].status[ebsl_pkg::POS_ADDRESS_VALID_FLAG] = err_ev.addr_valid;
            cand[b].status[ebsl_pkg::POS_EXTRA_INFO_VALID_FLAG] = err_ev.misc_valid;
            // correctable errors have no enable bit
            cand[b].status[ebsl_pkg::POS_EN] = err_ev.uc & s_r.ctl[b][err_ev.ctl_idx];
            cand[b].status[ebsl_pkg::POS_UC] = err_ev.uc;
            cand[b].addr = err_ev.addr_valid ? err_ev.address : 32'h0;
            cand[b].misc = err_ev.misc_valid ? err_ev.misc : 32'h0;
         end

         ebsl_bank u_bank (
            .old_ent  (s_r.ent[b]),
            .clr_val  (clr_val[b]),
            .clr_over (clr_over[b]),
            .hit      (hit[b]),
            .cand     (cand[b]),
            .nxt_ent  (ent_w[b])
         );
      end
   endgenerate

   always_comb begin
      s_nxt     = s_r;
      s_nxt.cnt = cnt_nxt;
      for (int i = 0; i < ebsl_pkg::NUM_BANKS; i++) begin
         s_nxt.ent[i]   = ent_w[i];
         s_nxt.vflag[i] = ent_w[i].status[ebsl_pkg::POS_VAL];
      end
      if (reg_wr && bank_ok && (sel_reg == ebsl_pkg::REG_CTL)) begin
         s_nxt.ctl[sel_bank] = reg_wdata[7:0];
      end
      // read data stand only in the cycle after the strobe
      s_nxt.rdata = 32'h0;
      if (reg_rd && bank_ok) begin
         case (sel_reg)
            ebsl_pkg::REG_STAT_LO: s_nxt.rdata = s_r.ent[sel_bank].status[31:0];
            ebsl_pkg::REG_STAT_HI: s_nxt.rdata = s_r.ent[sel_bank].status[63:32];
            ebsl_pkg::REG_ADDR:    s_nxt.rdata = s_r.ent[sel_bank].addr;
            ebsl_pkg::REG_MISC:    s_nxt.rdata = s_r.ent[sel_bank].misc;
            ebsl_pkg::REG_CTL:     s_nxt.rdata = {24'h0, s_r.ctl[sel_bank]};
            default:               s_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ebsl_pkg::NUM_BANKS; i++) begin
            s_r.ent[i].status <= ebsl_pkg::STAT_RST;
            s_r.ent[i].addr   <= 32'h0;
            s_r.ent[i].misc   <= 32'h0;
            s_r.ctl[i]        <= ebsl_pkg::CTL_RST;
         end
         s_r.cnt   <= ebsl_pkg::CNT_RST;
         s_r.rdata <= 32'h0;
         s_r.vflag <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata  = s_r.rdata;
   assign bank_valid = s_r.vflag;

   // checks on the cache/bus bank, plus the entry-valid hold check on bank 0
   logic [63:0] cbs;
   logic        cb_hit;
   logic        cb_live;

   assign cbs     = s_r.ent[ebsl_pkg::CB_BANK].status;
   assign cb_hit  = hit[ebsl_pkg::CB_BANK];
   assign cb_live = cbs[ebsl_pkg::POS_VAL] && !clr_val[ebsl_pkg::CB_BANK];

   default clocking cb_clk @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_internal_code: assert property (
      cb_hit && !cb_live && err_ev.kind == ebsl_pkg::EBSL_INTERNAL
      |=> cbs[15:0] == 16'h0400)
      else $error("internal error code wrong");
   chk_tag_code: assert property (
      cb_hit && !cb_live && err_ev.kind == ebsl_pkg::EBSL_L3TAG
      |=> cbs[15:0] == 16'h010b)
      else $error("cache tag error code wrong");
   chk_bus_code: assert property (
      cb_hit && !cb_live && err_ev.kind == ebsl_pkg::EBSL_BUS
      |=> cbs[15:0] == 16'h0e0f)
      else $error("bus error code wrong");
   chk_code_legal: assert property (
      cbs[ebsl_pkg::POS_VAL] |->
      cbs[15:0] inside {16'h0400, 16'h010b, 16'h0e0f})
      else $error("reserved error code logged");
   chk_pcc_on_uc: assert property (
      cbs[ebsl_pkg::POS_VAL] && cbs[ebsl_pkg::POS_UC] |-> cbs[ebsl_pkg::POS_PCC])
      else $error("uncorrected entry lacks context corrupt");
   chk_en_corr: assert property (
      cbs[ebsl_pkg::POS_VAL] && !cbs[ebsl_pkg::POS_UC] |-> !cbs[ebsl_pkg::POS_EN])
      else $error("correctable entry shows enabled");
   chk_over_set: assert property (
      cb_hit && cb_live |=> cbs[ebsl_pkg::POS_OVER] && cbs[ebsl_pkg::POS_VAL])
      else $error("overflow not set");
   chk_uc_keep: assert property (
      cb_hit && cb_live && cbs[ebsl_pkg::POS_UC] && err_ev.uc
      |=> cbs[56:0] == $past(cbs[56:0]) && cbs[ebsl_pkg::POS_UC])
      else $error("uncorrected entry overwritten");
   chk_val_set: assert property (
      hit[0] ##1 !clr_val[0] [*2] |-> s_r.ent[0].status[ebsl_pkg::POS_VAL] &&
      bank_valid[0])
      else $error("entry valid not held");
   chk_address_valid_flag_cap: assert property (
      cb_hit && !cb_live && err_ev.addr_valid
      |=> cbs[ebsl_pkg::POS_ADDRESS_VALID_FLAG] &&
      s_r.ent[ebsl_pkg::CB_BANK].addr == $past(err_ev.address))
      else $error("address not captured");
   chk_count_sat: assert property (
      s_r.cnt == 8'hff |=> s_r.cnt == 8'hff)
      else $error("event count wrapped");
   chk_count_step: assert property (
      ce_ev && s_r.cnt != 8'hff |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
      else $error("event count missed a step");
   chk_read_data: assert property (
      reg_rd && sel_bank == 3'h4 && sel_reg == ebsl_pkg::REG_STAT_HI
      |=> reg_rdata[31] == $past(cbs[ebsl_pkg::POS_VAL]) ##1 reg_rdata == 32'h0 || $past(reg_rd))
      else $error("status read wrong");

   cov_overflow: cover property (cb_hit && cb_live);
   cov_uc_replace: cover property (
      cb_hit && cb_live && err_ev.uc && !cbs[ebsl_pkg::POS_UC]);
   cov_clear_and_set: cover property (cb_hit && clr_val[ebsl_pkg::CB_BANK]);
   cov_saturate: cover property (ce_ev && s_r.cnt == 8'hff);
endmodule : ebsl_top
`default_nettype wire

// ### dv/tb_top.sv
/*
 self-checking bench of the error bank status logger: scenario tasks drive the
 register port and the error source and judge the status words read back.
 assumes ebsl_pkg and ebsl_top are compiled first; one 25 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                     mclk;
   logic                     rst;
   logic [5:0]               reg_addr;
   logic [31:0]              reg_wdata;
   logic                     reg_wr;
   logic                     reg_rd;
   logic [31:0]              reg_rdata;
   ebsl_pkg::ebsl_event_type err_ev;
   logic [4:0]               bank_valid;
   int                       n_fail;
   int                       compares;
   logic [63:0]              st;
   logic [31:0]              rv;

   ebsl_top uut (
      .mclk      (mclk),
      .rst       (rst),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .err_ev    (err_ev),
      .bank_valid(bank_valid)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic reg_write(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      // let the write edge settle before any caller looks at bank_valid
      #1;
   endtask : reg_write

   // data stands only one cycle, so it is taken then and checked gone after
   task automatic reg_read(input logic [5:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
      @(posedge mclk);
      #1 chk(reg_rdata, 64'h0);
   endtask : reg_read

   task automatic read_stat(input logic [2:0] b, output logic [63:0] s);
      reg_read({b, 3'h1}, s[63:32]);
      reg_read({b, 3'h0}, s[31:0]);
   endtask : read_stat

   // n back-to-back events, one per cycle
   task automatic send_ev(input ebsl_pkg::ebsl_event_type e, input int n);
      @(posedge mclk);
      err_ev <= e;
      repeat (n) @(posedge mclk);
      err_ev <= '0;
   endtask : send_ev

   task automatic t_reset();
      read_stat(3'h0, st);
      chk(st, 64'h0);
      reg_read(6'h24, rv);
      chk(rv, 64'h0);
      reg_read(6'h2d, rv);
      chk(rv, 64'h0);
      chk(bank_valid, 64'h0);
   endtask : t_reset

   task automatic t_plain();
      ebsl_pkg::ebsl_event_type e;
      e = '0;
      e.valid      = 1'b1;
      e.arch_code  = 16'h0135;
      e.model_code = 16'ha5c3;
      e.other_info = 25'h1abcdef;
      e.addr_valid = 1'b1;
      e.address    = 32'hdead0000;
      e.misc       = 32'h5555aaaa;
      send_ev(e, 1);
      read_stat(3'h0, st);
      chk(st[15:0], 16'h0135);
      chk(st[31:16], 16'ha5c3);
      chk(st[56:32], 25'h1abcdef);
      chk(st[63:57], 7'h42);
      reg_read(6'h02, rv);
      chk(rv, 32'hdead0000);
      // extra-info-valid is clear here, so software must not read that register
      chk(st[59], 1'b0);
   endtask : t_plain

   task automatic t_priority();
      ebsl_pkg::ebsl_event_type e;
      e = '0;
      e.valid      = 1'b1;
      e.uc         = 1'b1;
      e.model_code = 16'h2222;
      e.misc_valid = 1'b1;
      e.misc       = 32'h12345678;
      reg_write(6'h04, 32'h1);
      send_ev(e, 1);
      read_stat(3'h0, st);
      chk(st[31:16], 16'h2222);
      chk(st[63:57], 7'h7d);
      reg_read(6'h03, rv);
      chk(rv, 32'h12345678);
      // address-valid is clear here, so the address register stays unread
      chk(st[58], 1'b0);
      // a second uncorrected error must leave the first in place
      e.model_code = 16'h3333;
      send_ev(e, 1);
      read_stat(3'h0, st);
      chk(st[31:16], 16'h2222);
      chk(st[63:57], 7'h7d);
      reg_write(6'h01, 32'h0);
      chk(bank_valid, 64'h0);
      read_stat(3'h0, st);
      chk(st[63:62], 2'h0);
   endtask : t_priority

   task automatic t_codes();
      ebsl_pkg::ebsl_event_type e;
      ebsl_pkg::ebsl_kind_type  k[3];
      logic [15:0]              c[3];
      k = '{ebsl_pkg::EBSL_INTERNAL, ebsl_pkg::EBSL_L3TAG, ebsl_pkg::EBSL_BUS};
      c = '{16'h0400, 16'h010b, 16'h0e0f};
      for (int i = 0; i < 3; i++) begin
         e = '0;
         e.valid      = 1'b1;
         e.bank       = 3'h4;
         e.kind       = k[i];
         e.arch_code  = 16'hffff;
         e.uc         = 1'b1;
         e.ctl_idx    = 3'h1;
         e.misc_fmt   = 2'h2;
         e.other_info = 25'h1fffc00;
         send_ev(e, 1);
         read_stat(3'h4, st);
         chk(st[15:0], c[i]);
         chk(st[63:57], 7'h51);
         chk(st[56:40], 17'h1fffe);
         reg_write(6'h21, 32'h0);
         chk(bank_valid, 64'h0);
      end
   endtask : t_codes

   task automatic t_count();
      ebsl_pkg::ebsl_event_type e;
      e = '0;
      e.valid = 1'b1;
      e.bank  = 3'h4;
      e.kind  = ebsl_pkg::EBSL_BUS;
      send_ev(e, 1);
      read_stat(3'h4, st);
      chk(st[39:32], 8'h01);
      chk(st[63:57], 7'h40);
      send_ev(e, 255);
      read_stat(3'h4, st);
      chk(st[62], 1'b1);
      reg_write(6'h21, 32'h0);
      // 257 events in all: the count must stick at its ceiling
      send_ev(e, 1);
      read_stat(3'h4, st);
      chk(st[39:32], 8'hff);
      reg_write(6'h21, 32'h0);
   endtask : t_count

   task automatic t_banks();
      ebsl_pkg::ebsl_event_type e;
      e = '0;
      e.valid = 1'b1;
      for (int b = 0; b < 6; b++) begin
         e.bank = 3'(b);
         send_ev(e, 1);
         @(posedge mclk);
         chk(bank_valid, (b < 5) ? 64'(5'h1 << b) : 64'h0);
         reg_write({3'(b), 3'h1}, 32'h0);
      end
   endtask : t_banks

   initial begin
      rst       = 1'b1;
      reg_addr  = '0;
      reg_wdata = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      err_ev    = '0;
      n_fail    = 0;
      compares  = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_plain();
      t_priority();
      t_codes();
      t_count();
      t_banks();
      report_and_stop();
   end

   // the whole run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
